// File: iepb_consts.svh
// offsets, field positions, reset values and widths for the priority enable bank
`ifndef IEPB_CONSTS_SVH
`define IEPB_CONSTS_SVH

`define IEPB_ADDR_W          24
`define IEPB_OFF_G1_ENH      24'hffe036
`define IEPB_OFF_G1_ENL      24'hffe037
`define IEPB_OFF_G2_REQ      24'hffe038
`define IEPB_OFF_G2_FORCE    24'hffe039
`define IEPB_OFF_G2_ENH      24'hffe03a
`define IEPB_OFF_G2_ENL      24'hffe03b
`define IEPB_OFF_G1_REQ      24'hffe034
`define IEPB_OFF_STATUS      24'hffe040
`define IEPB_OFF_MASK        24'hffe041
`define IEPB_OFF_WIN         24'hffe042
`define IEPB_RST_BYTE        8'h00
`define IEPB_BIT_PWM_PERIOD  7
`define IEPB_BIT_SER1_RX     6
`define IEPB_BIT_SER1_TX     5
`define IEPB_BIT_PWM_TRIP    4
`define IEPB_STAT_WIN_CHANGE 0
`define IEPB_STAT_DROP       1

`endif

// File: iepb_pkg.sv
// types shared by the priority enable bank
package iepb_pkg;
   typedef logic [1:0] iepb_level_t;
   typedef enum logic [1:0] {
      IEPB_BUS_IDLE = 2'b00,
      IEPB_BUS_ACK  = 2'b01
   } iepb_bus_state_t;
endpackage

// File: iepb_encoder.sv
// priority encoder: highest level wins, lowest index breaks ties
`timescale 1ns/1ps
`default_nettype none
module iepb_encoder (
   input  wire logic [15:0]        pend,
   input  wire logic [15:0]        en_high,
   input  wire logic [15:0]        en_low,
   output logic                    any,
   output logic [3:0]              index,
   output iepb_pkg::iepb_level_t   level
);
   always_comb begin
      any   = 1'b0;
      index = 4'h0;
      level = 2'h0;
      for (int i = 15; i >= 0; i--) begin
         // RULE_07 level gated arbitration
         if (pend[i] && {en_high[i], en_low[i]} != 2'b00
             && {en_high[i], en_low[i]} >= level) begin
            any   = 1'b1;
            index = 4'(i);
            level = {en_high[i], en_low[i]};
         end
      end
   end
endmodule
`default_nettype wire

// File: iepb_top.sv
// priority enable bank for port A/D and group-two requests, Avalon-MM slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iepb_consts.svh"
// Operation
// RULE_01: enable pair selects off or level 1-3
// RULE_02: port A/D high enable at ffe036
// RULE_03: port A/D low enable at ffe037
// RULE_04: group two bits 7-4 map fixed sources
// RULE_05: group two bits 3-0 port C/channel
// RULE_06: group two low enable at ffe03b
// RULE_07: enabled pending requests, highest level wins
// RULE_08: write one clears group two request
// RULE_09: force register sets group two requests
module iepb_top (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   input  wire logic [23:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [7:0]  avs_writedata,
   output logic      [7:0]  avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [7:0]  src_group_one,
   input  wire logic [7:0]  src_group_two,
   output logic             arb_valid,
   output logic      [3:0]  arb_index,
   output logic      [1:0]  arb_level,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] port_ad_irq_enable_high;
   logic [7:0] port_ad_irq_enable_low;
   logic [7:0] group_two_irq_enable_high;
   logic [7:0] group_two_irq_enable_low;
   logic [7:0] request_group_one;
   logic [7:0] request_group_two;
   logic [7:0] status;
   logic [7:0] mask;
   iepb_pkg::iepb_bus_state_t state;
   logic       wr_fire;
   logic       rd_fire;
   logic       enc_any;
   logic [3:0] enc_index;
   iepb_pkg::iepb_level_t enc_level;

   function automatic logic hit(input logic [23:0] a, input logic [23:0] off);
      hit = (a == off);
   endfunction

   // writes land at the acknowledge edge; read data is caught when the request
   // is taken, so it already stands while waitrequest is low
   assign wr_fire = clk_en && state == iepb_pkg::IEPB_BUS_ACK && avs_write;
   assign rd_fire = clk_en && state == iepb_pkg::IEPB_BUS_IDLE && avs_read;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= iepb_pkg::IEPB_BUS_IDLE;
      end else if (clk_en) begin
         unique case (state)
            iepb_pkg::IEPB_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  state <= iepb_pkg::IEPB_BUS_ACK;
               end
            end
            iepb_pkg::IEPB_BUS_ACK: begin
               state <= iepb_pkg::IEPB_BUS_IDLE;
            end
            default: begin
               state <= iepb_pkg::IEPB_BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else if (clk_en) begin
         avs_waitrequest <= !(state == iepb_pkg::IEPB_BUS_IDLE
                              && (avs_read || avs_write));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         port_ad_irq_enable_high   <= `IEPB_RST_BYTE;
         port_ad_irq_enable_low    <= `IEPB_RST_BYTE;
         group_two_irq_enable_high <= `IEPB_RST_BYTE;
         group_two_irq_enable_low  <= `IEPB_RST_BYTE;
         mask                      <= `IEPB_RST_BYTE;
      end else if (wr_fire) begin
         // RULE_02 port A/D high enable
         if (hit(avs_address, `IEPB_OFF_G1_ENH)) begin
            port_ad_irq_enable_high <= avs_writedata;
         end
         // RULE_03 port A/D low enable
         if (hit(avs_address, `IEPB_OFF_G1_ENL)) begin
            port_ad_irq_enable_low <= avs_writedata;
         end
         // RULE_04 group two high enable
         if (hit(avs_address, `IEPB_OFF_G2_ENH)) begin
            group_two_irq_enable_high <= avs_writedata;
         end
         // RULE_06 group two low enable
         if (hit(avs_address, `IEPB_OFF_G2_ENL)) begin
            group_two_irq_enable_low <= avs_writedata;
         end
         if (hit(avs_address, `IEPB_OFF_MASK)) begin
            mask <= avs_writedata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source pulses set pending bits; a set in the clear cycle wins
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         request_group_one <= `IEPB_RST_BYTE;
      end else if (clk_en) begin
         if (wr_fire && hit(avs_address, `IEPB_OFF_G1_REQ)) begin
            request_group_one <= (request_group_one & ~avs_writedata) | src_group_one;
         end else begin
            request_group_one <= request_group_one | src_group_one;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         request_group_two <= `IEPB_RST_BYTE;
      end else if (clk_en) begin
         // RULE_05 bits 3-0 from port C or channel sources
         if (wr_fire && hit(avs_address, `IEPB_OFF_G2_REQ)) begin
            // RULE_08 write one clears
            request_group_two <= (request_group_two & ~avs_writedata) | src_group_two;
         end else if (wr_fire && hit(avs_address, `IEPB_OFF_G2_FORCE)) begin
            // RULE_09 force sets bits
            request_group_two <= request_group_two | avs_writedata | src_group_two;
         end else begin
            request_group_two <= request_group_two | src_group_two;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   iepb_encoder u_enc (
      .pend    ({request_group_two, request_group_one}),
      .en_high ({group_two_irq_enable_high, port_ad_irq_enable_high}),
      .en_low  ({group_two_irq_enable_low, port_ad_irq_enable_low}),
      .any     (enc_any),
      .index   (enc_index),
      .level   (enc_level)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         arb_valid <= 1'b0;
         arb_index <= 4'h0;
         arb_level <= 2'h0;
      end else if (clk_en) begin
         // RULE_01 pair gives presented level
         arb_valid <= enc_any;
         arb_index <= enc_index;
         arb_level <= enc_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status: bit0 winner changed, bit1 request arrived while source disabled
   logic [7:0] stat_set;
   always_comb begin
      stat_set = 8'h00;
      stat_set[`IEPB_STAT_WIN_CHANGE] = enc_any
         && (!arb_valid || enc_index != arb_index || enc_level != arb_level);
      stat_set[`IEPB_STAT_DROP] =
         |(({src_group_two, src_group_one})
           & ~({group_two_irq_enable_high, port_ad_irq_enable_high}
               | {group_two_irq_enable_low, port_ad_irq_enable_low}));
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         status <= `IEPB_RST_BYTE;
      end else if (clk_en) begin
         if (wr_fire && hit(avs_address, `IEPB_OFF_STATUS)) begin
            status <= (status & ~avs_writedata) | stat_set;
         end else begin
            status <= status | stat_set;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(status & mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // force register reads zero: it is write only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         avs_readdata <= 8'h00;
      end else if (rd_fire) begin
         unique case (avs_address)
            `IEPB_OFF_G1_ENH:    avs_readdata <= port_ad_irq_enable_high;
            `IEPB_OFF_G1_ENL:    avs_readdata <= port_ad_irq_enable_low;
            `IEPB_OFF_G2_ENH:    avs_readdata <= group_two_irq_enable_high;
            `IEPB_OFF_G2_ENL:    avs_readdata <= group_two_irq_enable_low;
            `IEPB_OFF_G1_REQ:    avs_readdata <= request_group_one;
            `IEPB_OFF_G2_REQ:    avs_readdata <= request_group_two;
            `IEPB_OFF_STATUS:    avs_readdata <= status;
            `IEPB_OFF_MASK:      avs_readdata <= mask;
            `IEPB_OFF_WIN:       avs_readdata <= {arb_valid, 1'b0, arb_level, arb_index};
            default:             avs_readdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_force_sets;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G2_FORCE)
         |=> ((request_group_two & $past(avs_writedata)) == $past(avs_writedata));
   endproperty
   a_force_sets: assert property (p_force_sets) else $error("force did not set"); // RULE_09

   property p_w1c;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G2_REQ) && src_group_two == 8'h00
         |=> ((request_group_two & $past(avs_writedata)) == 8'h00);
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear"); // RULE_08

   property p_w0_keeps;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G2_REQ)
         |=> ((request_group_two & ~$past(avs_writedata))
              == (($past(request_group_two) | $past(src_group_two))
                  & ~$past(avs_writedata)));
   endproperty
   a_w0_keeps: assert property (p_w0_keeps) else $error("write zero changed bit"); // RULE_08

   property p_enh_write;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G1_ENH)
         |=> port_ad_irq_enable_high == $past(avs_writedata);
   endproperty
   a_enh_write: assert property (p_enh_write) else $error("group one high lost"); // RULE_02

   property p_enl_write;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G1_ENL)
         |=> port_ad_irq_enable_low == $past(avs_writedata);
   endproperty
   a_enl_write: assert property (p_enl_write) else $error("group one low lost"); // RULE_03

   property p_g2h_write;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G2_ENH)
         |=> group_two_irq_enable_high == $past(avs_writedata);
   endproperty
   a_g2h_write: assert property (p_g2h_write) else $error("group two high lost"); // RULE_04

   property p_g2l_write;
      @(posedge ref_clk) disable iff (srst)
      wr_fire && hit(avs_address, `IEPB_OFF_G2_ENL)
         |=> group_two_irq_enable_low == $past(avs_writedata);
   endproperty
   a_g2l_write: assert property (p_g2l_write) else $error("group two low lost"); // RULE_06

   property p_src_latch;
      @(posedge ref_clk) disable iff (srst)
      clk_en && src_group_two[3:0] != 4'h0
         |=> (request_group_two[3:0] & $past(src_group_two[3:0])) == $past(src_group_two[3:0]);
   endproperty
   a_src_latch: assert property (p_src_latch) else $error("shared source lost"); // RULE_05

   property p_level_match;
      @(posedge ref_clk) disable iff (srst)
      clk_en && enc_any |=> arb_valid && arb_level == $past(enc_level) && arb_level != 2'h0;
   endproperty
   a_level_match: assert property (p_level_match) else $error("level not presented"); // RULE_01

   property p_no_disabled;
      @(posedge ref_clk) disable iff (srst)
      clk_en && !enc_any |=> !arb_valid;
   endproperty
   a_no_disabled: assert property (p_no_disabled) else $error("idle winner shown"); // RULE_07

   sequence s_req;
      state == iepb_pkg::IEPB_BUS_IDLE && (avs_read || avs_write) && clk_en;
   endsequence
   property p_one_wait;
      @(posedge ref_clk) disable iff (srst)
      s_req |=> !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("no answer after wait");
endmodule
`default_nettype wire

// File: iepb_src_model.sv
// request source model: one-cycle pulses on the two group inputs
`timescale 1ns/1ps
`default_nettype none
module iepb_src_model (
   input  wire logic       ref_clk,
   output logic      [7:0] src_group_one,
   output logic      [7:0] src_group_two
);
   initial begin
      src_group_one = 8'h00;
      src_group_two = 8'h00;
   end
   ////////////////////////////////////////////////////////////////
   // gap lets a source answer late; pulses never stretch past a cycle
   task automatic pulse(input logic [7:0] g1, input logic [7:0] g2, input int gap);
      repeat (gap) @(posedge ref_clk);
      @(posedge ref_clk);
      src_group_one <= g1;
      src_group_two <= g2;
      @(posedge ref_clk);
      src_group_one <= 8'h00;
      src_group_two <= 8'h00;
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the priority enable bank
`timescale 1ns/1ps
`default_nettype none
`include "iepb_consts.svh"
module tb_top;
   logic        ref_clk       = 1'b0;
   logic        srst          = 1'b1;
   logic        clk_en        = 1'b1;
   logic [23:0] avs_address   = 24'h000000;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [7:0]  avs_writedata = 8'h00;
   logic [7:0]  avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  src_group_one;
   logic [7:0]  src_group_two;
   logic        arb_valid;
   logic [3:0]  arb_index;
   logic [1:0]  arb_level;
   logic        irq;
   logic [7:0]  exp_q[$];
   logic [31:0] seed          = 32'h70b9;
   logic [23:0] regs[4]       = '{`IEPB_OFF_G1_ENH, `IEPB_OFF_G1_ENL,
                                  `IEPB_OFF_G2_ENH, `IEPB_OFF_G2_ENL};
   int          num_errors    = 0;
   int          compares      = 0;

   always #50 ref_clk = ~ref_clk;

   iepb_top iepb_top_inst (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src_group_one(src_group_one),
      .src_group_two(src_group_two), .arb_valid(arb_valid),
      .arb_index(arb_index), .arb_level(arb_level), .irq(irq)
   );
   iepb_src_model iepb_src_model_inst (
      .ref_clk(ref_clk), .src_group_one(src_group_one), .src_group_two(src_group_two)
   );
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic rd, input logic [23:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         num_errors++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic irq_is(input logic e);
      check({7'h00, irq}, {7'h00, e});
   endtask
   ////////////////////////////////////////////////////////////////
   // read data is compared at the edge the slave answers
   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0)
            num_errors++;
         else
            check(avs_readdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      foreach (regs[i]) rd(regs[i], `IEPB_RST_BYTE);
      rd(24'hffe03c, 8'h00);
      rd(`IEPB_OFF_G2_FORCE, 8'h00);
      foreach (regs[i]) begin
         seed = xs(seed);
         wr(regs[i], seed[7:0]);
         rd(regs[i], seed[7:0]);
      end
      for (int lv = 0; lv < 4; lv++) begin
         wr(`IEPB_OFF_G1_ENH, {7'h00, lv[1]});
         wr(`IEPB_OFF_G1_ENL, {7'h00, lv[0]});
         iepb_src_model_inst.pulse(8'h01, 8'h00, lv);
         idle(2);
         rd(`IEPB_OFF_WIN, (lv == 0) ? 8'h00 : {2'b10, lv[1:0], 4'h0});
         wr(`IEPB_OFF_G1_REQ, 8'h01);
      end
      wr(`IEPB_OFF_G2_ENH, 8'hff);
      wr(`IEPB_OFF_G2_ENL, 8'h0f);
      for (int b = 0; b < 8; b++) begin
         iepb_src_model_inst.pulse(8'h00, 8'h01 << b, 0);
         idle(2);
         rd(`IEPB_OFF_WIN, {2'b10, (b < 4) ? 2'b11 : 2'b10, 4'(b + 8)});
         wr(`IEPB_OFF_G2_REQ, 8'h01 << b);
         rd(`IEPB_OFF_WIN, 8'h00);
      end
      // low-level source at a lower index must lose to higher levels
      wr(`IEPB_OFF_G1_ENH, 8'h00);
      wr(`IEPB_OFF_G1_ENL, 8'h80);
      wr(`IEPB_OFF_G2_ENL, 8'h80);
      iepb_src_model_inst.pulse(8'h80, 8'h88, 1);
      idle(2);
      rd(`IEPB_OFF_WIN, 8'hbf);
      wr(`IEPB_OFF_G2_REQ, 8'h00);
      rd(`IEPB_OFF_G2_REQ, 8'h88);
      wr(`IEPB_OFF_G2_REQ, 8'h80);
      rd(`IEPB_OFF_WIN, 8'hab);
      wr(`IEPB_OFF_G2_REQ, 8'h08);
      rd(`IEPB_OFF_WIN, 8'h97);
      wr(`IEPB_OFF_G1_REQ, 8'h80);
      rd(`IEPB_OFF_WIN, 8'h00);
      wr(`IEPB_OFF_G2_FORCE, 8'h21);
      rd(`IEPB_OFF_G2_REQ, 8'h21);
      rd(`IEPB_OFF_G2_FORCE, 8'h00);
      wr(`IEPB_OFF_G2_REQ, 8'h21);
      wr(`IEPB_OFF_STATUS, 8'h03);
      wr(`IEPB_OFF_MASK, 8'h01);
      idle(2);
      irq_is(1'b0);
      rd(`IEPB_OFF_MASK, 8'h01);
      iepb_src_model_inst.pulse(8'h00, 8'h80, 2);
      idle(3);
      irq_is(1'b1);
      wr(`IEPB_OFF_MASK, 8'h00);
      idle(2);
      irq_is(1'b0);
      wr(`IEPB_OFF_MASK, 8'h01);
      idle(2);
      irq_is(1'b1);
      wr(`IEPB_OFF_G2_REQ, 8'h80);
      idle(3);
      wr(`IEPB_OFF_STATUS, 8'h01);
      idle(2);
      irq_is(1'b0);
      // disabled source only flags status bit 1, which stays masked
      iepb_src_model_inst.pulse(8'h01, 8'h00, 0);
      idle(2);
      rd(`IEPB_OFF_STATUS, 8'h02);
      irq_is(1'b0);
      // frozen clock enable: an enabled source pulse must not be latched
      clk_en <= 1'b0;
      iepb_src_model_inst.pulse(8'h00, 8'h80, 0);
      idle(2);
      irq_is(1'b0);
      clk_en <= 1'b1;
      rd(`IEPB_OFF_G2_REQ, 8'h00);
      rd(`IEPB_OFF_WIN, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
